// >>> verilog/fec_defs.svh
// Register offsets, field positions, flash command codes and timing counts
`ifndef FEC_DEFS_SVH
`define FEC_DEFS_SVH

// Register offsets on the APB side
`define FEC_REG_CTRL        8'h00
`define FEC_REG_ADDR        8'h04
`define FEC_REG_WDATA       8'h08
`define FEC_REG_STATUS      8'h0C
`define FEC_REG_RDATA       8'h10

// Status field positions
`define FEC_ST_BUSY         0
`define FEC_ST_READY        1
`define FEC_ST_WINDOW       2
`define FEC_ST_REFUSED      3
`define FEC_ST_ABORTED      4
`define FEC_ST_ERASE_LIVE   5

// Reset values
`define FEC_ADDR_RST        18'h00000
`define FEC_DATA_RST        8'h00

// Flash command addresses and codes
`define FEC_UNLOCK_A1       18'h00555
`define FEC_UNLOCK_A2       18'h002AA
`define FEC_UNLOCK_D1       8'hAA
`define FEC_UNLOCK_D2       8'h55
`define FEC_CMD_SETUP       8'h80
`define FEC_CMD_CHIP        8'h10
`define FEC_CMD_SECTOR      8'h30
`define FEC_CMD_PROGRAM     8'hA0
`define FEC_CMD_AUTOSEL     8'h90
`define FEC_CMD_SUSPEND     8'hB0
`define FEC_CMD_RESUME      8'h30
`define FEC_CMD_RESET       8'hF0
`define FEC_SECTOR_HI       17
`define FEC_SECTOR_LO       13

// Timing: clock period, times in ns, counts derived from them
`define FEC_CLK_NS          100
`define FEC_T_WP_NS         100
`define FEC_T_ACC_NS        150
`define FEC_T_RP_NS         500
`define FEC_T_RH_NS         200
`define FEC_T_WIN_NS        50000
`define FEC_WP_CYC          ((`FEC_T_WP_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)
`define FEC_ACC_CYC         ((`FEC_T_ACC_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)
`define FEC_RP_CYC          ((`FEC_T_RP_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)
`define FEC_RH_CYC          ((`FEC_T_RH_NS + `FEC_CLK_NS - 1) / `FEC_CLK_NS)
`define FEC_WIN_CYC         (`FEC_T_WIN_NS / `FEC_CLK_NS)
`define FEC_WIN_GUARD_CYC   10

`endif

// >>> verilog/fec_pkg.sv
// Types shared by the flash erase controller
package fec_pkg;

    // Operations software can launch
    typedef enum logic [3:0] {
        FEC_OP_CHIP_ERASE   = 4'h0,
        FEC_OP_SECTOR_ERASE = 4'h1,
        FEC_OP_ADD_SECTOR   = 4'h2,
        FEC_OP_SUSPEND      = 4'h3,
        FEC_OP_RESUME       = 4'h4,
        FEC_OP_RESET_CMD    = 4'h5,
        FEC_OP_READ         = 4'h6,
        FEC_OP_AUTOSELECT   = 4'h7,
        FEC_OP_PROGRAM      = 4'h8,
        FEC_OP_HW_RESET     = 4'h9
    } fec_op_t;

    // One bus cycle of a command sequence
    typedef struct packed {
        logic        last;
        logic        rd;
        logic [17:0] addr;
        logic [7:0]  data;
    } fec_cycle_t;

    // Sequencer states
    typedef enum logic [2:0] {
        FEC_SQ_IDLE  = 3'b000,
        FEC_SQ_ISSUE = 3'b001,
        FEC_SQ_WAIT  = 3'b010,
        FEC_SQ_HWRST = 3'b011,
        FEC_SQ_RECOV = 3'b100
    } fec_seq_state_t;

    // Bus cycle engine states
    typedef enum logic [2:0] {
        FEC_CY_IDLE   = 3'b000,
        FEC_CY_SETUP  = 3'b001,
        FEC_CY_STROBE = 3'b010,
        FEC_CY_HOLD   = 3'b011,
        FEC_CY_READ   = 3'b100,
        FEC_CY_END    = 3'b101
    } fec_cyc_state_t;

endpackage : fec_pkg

// >>> verilog/fec_bus_cycle.sv
// Single read or write cycle on the flash strobes
`include "fec_defs.svh"

module fec_bus_cycle
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        rd,
    input  wire logic [17:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  dq_in,
    output logic             done,
    output logic [7:0]       rdata,
    output logic [17:0]      flash_addr,
    output logic [7:0]       dq_out,
    output logic             dq_oe,
    output logic             ce_n,
    output logic             we_n,
    output logic             oe_n
);

    fec_pkg::fec_cyc_state_t state;
    fec_pkg::fec_cyc_state_t next_state;
    logic [3:0]              cnt;
    logic [3:0]              next_cnt;
    logic                    rd_q;

    // Cycle sequencing
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            fec_pkg::FEC_CY_IDLE:
                if (start)
                    next_state = fec_pkg::FEC_CY_SETUP;
            fec_pkg::FEC_CY_SETUP:
                if (rd_q)
                begin
                    next_state = fec_pkg::FEC_CY_READ;
                    next_cnt   = 4'(`FEC_ACC_CYC - 1);
                end
                else
                begin
                    next_state = fec_pkg::FEC_CY_STROBE;
                    next_cnt   = 4'(`FEC_WP_CYC - 1);
                end
            fec_pkg::FEC_CY_STROBE:
                if (cnt == 4'h0)
                    next_state = fec_pkg::FEC_CY_HOLD;
                else
                    next_cnt = cnt - 4'h1;
            fec_pkg::FEC_CY_HOLD:
                next_state = fec_pkg::FEC_CY_END;
            fec_pkg::FEC_CY_READ:
                if (cnt == 4'h0)
                    next_state = fec_pkg::FEC_CY_END;
                else
                    next_cnt = cnt - 4'h1;
            fec_pkg::FEC_CY_END:
                next_state = fec_pkg::FEC_CY_IDLE;
            default:
                next_state = fec_pkg::FEC_CY_IDLE;
        endcase
    end

    // State and request latch
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state      <= fec_pkg::FEC_CY_IDLE;
            cnt        <= 4'h0;
            rd_q       <= 1'b0;
            flash_addr <= `FEC_ADDR_RST;
            dq_out     <= `FEC_DATA_RST;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
            if (state == fec_pkg::FEC_CY_IDLE && start)
            begin
                rd_q       <= rd;
                flash_addr <= addr;
                dq_out     <= wdata;
            end
        end
    end

    // Strobes: chip select first, write strobe inside it, output strobe high on writes
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            ce_n  <= 1'b1;
            we_n  <= 1'b1;
            oe_n  <= 1'b1;
            dq_oe <= 1'b0;
            done  <= 1'b0;
            rdata <= `FEC_DATA_RST;
        end
        else
        begin
            ce_n  <= (next_state == fec_pkg::FEC_CY_IDLE) || (next_state == fec_pkg::FEC_CY_END);
            we_n  <= next_state != fec_pkg::FEC_CY_STROBE;
            oe_n  <= next_state != fec_pkg::FEC_CY_READ;
            dq_oe <= (next_state == fec_pkg::FEC_CY_STROBE) || (next_state == fec_pkg::FEC_CY_HOLD);
            done  <= next_state == fec_pkg::FEC_CY_END;
            if (state == fec_pkg::FEC_CY_READ && cnt == 4'h0)
                rdata <= dq_in;
        end
    end

endmodule : fec_bus_cycle

// >>> verilog/fec_flash_ctrl.sv
// Host-side controller issuing erase and related command sequences to a parallel flash
`include "fec_defs.svh"

// Function
// - Chip erase: two unlocks, 80 at 555, two unlocks, 10 at 555.
// - Hardware reset aborts erase; host flags it so software reissues.
// - Sector erase: same five cycles, then 30 at the sector address.
// - Host spaces added sectors under 50 us or refuses late ones.
// - Host masks its interrupts while adding sectors; this controller has no interrupts and refuses late sectors instead.
// - F0 at any address is the reset command.
// - Write only with select and write strobe low, output strobe high.
module fec_flash_ctrl
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [17:0]      flash_addr,
    input  wire logic [7:0]  flash_dq_in,
    output logic [7:0]       flash_dq_out,
    output logic             flash_dq_oe,
    output logic             flash_ce_n,
    output logic             flash_we_n,
    output logic             flash_oe_n,
    output logic             flash_reset_n,
    input  wire logic        flash_ready_busy_n
);

    fec_pkg::fec_seq_state_t state;
    fec_pkg::fec_seq_state_t next_state;
    fec_pkg::fec_op_t        cur_op;
    fec_pkg::fec_cycle_t     cyc;
    logic [2:0]              step;
    logic [3:0]              rcnt;
    logic [17:0]             op_addr;
    logic [7:0]              op_data;
    logic [9:0]              win_cnt;
    logic                    win_open;
    logic                    refused;
    logic                    aborted;
    logic                    erase_live;
    logic                    rb_q;
    logic                    rb_prev;
    logic                    eng_done;
    logic [7:0]              eng_rdata;

    // One cycle of the sequence for an operation
    function automatic fec_pkg::fec_cycle_t fec_step(input fec_pkg::fec_op_t op,
                                                     input logic [2:0] idx,
                                                     input logic [17:0] a,
                                                     input logic [7:0] d);
        fec_pkg::fec_cycle_t c;
        logic [17:0]         sa;
        logic [7:0]          third;
        c     = '{last: 1'b0, rd: 1'b0, addr: `FEC_UNLOCK_A1, data: `FEC_UNLOCK_D1};
        sa    = {a[`FEC_SECTOR_HI:`FEC_SECTOR_LO], 13'h0000};
        third = (op == fec_pkg::FEC_OP_PROGRAM) ? `FEC_CMD_PROGRAM :
                (op == fec_pkg::FEC_OP_AUTOSELECT) ? `FEC_CMD_AUTOSEL : `FEC_CMD_SETUP;
        case (op)
            fec_pkg::FEC_OP_ADD_SECTOR:
                c = '{last: 1'b1, rd: 1'b0, addr: sa, data: `FEC_CMD_SECTOR};
            fec_pkg::FEC_OP_SUSPEND:
                c = '{last: 1'b1, rd: 1'b0, addr: a, data: `FEC_CMD_SUSPEND};
            fec_pkg::FEC_OP_RESUME:
                c = '{last: 1'b1, rd: 1'b0, addr: a, data: `FEC_CMD_RESUME};
            fec_pkg::FEC_OP_RESET_CMD:
                c = '{last: 1'b1, rd: 1'b0, addr: a, data: `FEC_CMD_RESET};
            fec_pkg::FEC_OP_READ:
                c = '{last: 1'b1, rd: 1'b1, addr: a, data: `FEC_DATA_RST};
            default:
            begin
                // Unlock pattern shared by all multi-cycle sequences
                case (idx)
                    3'd0: c = '{last: 1'b0, rd: 1'b0, addr: `FEC_UNLOCK_A1, data: `FEC_UNLOCK_D1};
                    3'd1: c = '{last: 1'b0, rd: 1'b0, addr: `FEC_UNLOCK_A2, data: `FEC_UNLOCK_D2};
                    3'd2: c = '{last: (op == fec_pkg::FEC_OP_AUTOSELECT), rd: 1'b0,
                                addr: `FEC_UNLOCK_A1, data: third};
                    3'd3:
                        if (op == fec_pkg::FEC_OP_PROGRAM)
                            c = '{last: 1'b1, rd: 1'b0, addr: a, data: d};
                    3'd4: c = '{last: 1'b0, rd: 1'b0, addr: `FEC_UNLOCK_A2, data: `FEC_UNLOCK_D2};
                    default:
                        if (op == fec_pkg::FEC_OP_SECTOR_ERASE)
                            c = '{last: 1'b1, rd: 1'b0, addr: sa, data: `FEC_CMD_SECTOR};
                        else
                            c = '{1'b1, 1'b0, `FEC_UNLOCK_A1, `FEC_CMD_CHIP};
                endcase
            end
        endcase
        return c;
    endfunction : fec_step

    // APB decode
    wire              apb_setup = psel & penable & ~pready;
    wire              apb_done  = psel & penable & pready;
    wire              apb_wr    = apb_done & pwrite;
    wire              hit       = (paddr == `FEC_REG_CTRL) || (paddr == `FEC_REG_ADDR) ||
                                  (paddr == `FEC_REG_WDATA) || (paddr == `FEC_REG_STATUS) ||
                                  (paddr == `FEC_REG_RDATA);
    wire              wr_ctrl   = apb_wr && (paddr == `FEC_REG_CTRL);
    wire              wr_stat   = apb_wr && (paddr == `FEC_REG_STATUS);
    wire [3:0]        req_raw   = pwdata[3:0];
    wire              req_legal = req_raw <= 4'h9;
    wire              req_add   = req_raw == 4'h2;
    wire              win_late  = win_cnt >= 10'(`FEC_WIN_CYC - `FEC_WIN_GUARD_CYC);
    wire              add_ok    = win_open && !win_late;
    wire              go_ok     = wr_ctrl && (state == fec_pkg::FEC_SQ_IDLE) && req_legal &&
                                  (!req_add || add_ok);
    wire              go_hwrst  = go_ok && (req_raw == 4'h9);
    wire              seq_end   = (state == fec_pkg::FEC_SQ_WAIT) && eng_done && cyc.last;
    wire              sect_end  = seq_end && ((cur_op == fec_pkg::FEC_OP_SECTOR_ERASE) ||
                                              (cur_op == fec_pkg::FEC_OP_ADD_SECTOR));
    wire              chip_end  = seq_end && (cur_op == fec_pkg::FEC_OP_CHIP_ERASE);
    wire              rb_rise   = rb_q && !rb_prev;
    wire [31:0]       status    = {26'h0000000, erase_live, aborted, refused, win_open, rb_q,
                                   state != fec_pkg::FEC_SQ_IDLE};
    wire [31:0]       rd_mux    = (paddr == `FEC_REG_ADDR)   ? {14'h0000, op_addr} :
                                  (paddr == `FEC_REG_WDATA)  ? {24'h000000, op_data} :
                                  (paddr == `FEC_REG_STATUS) ? status :
                                  (paddr == `FEC_REG_RDATA)  ? {24'h000000, eng_rdata} :
                                  {28'h0000000, cur_op};

    assign cyc = fec_step(cur_op, step, op_addr, op_data);

    // APB slave answer, one wait state
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= apb_setup;
            pslverr <= apb_setup && !hit;
            prdata  <= (apb_setup && !pwrite && hit) ? rd_mux : 32'h00000000;
        end
    end

    // Sequencer transitions
    always_comb
    begin
        next_state = state;
        case (state)
            fec_pkg::FEC_SQ_IDLE:
                if (go_hwrst)
                    next_state = fec_pkg::FEC_SQ_HWRST;
                else if (go_ok)
                    next_state = fec_pkg::FEC_SQ_ISSUE;
            fec_pkg::FEC_SQ_ISSUE:
                next_state = fec_pkg::FEC_SQ_WAIT;
            fec_pkg::FEC_SQ_WAIT:
                if (eng_done)
                    next_state = cyc.last ? fec_pkg::FEC_SQ_IDLE : fec_pkg::FEC_SQ_ISSUE;
            fec_pkg::FEC_SQ_HWRST:
                if (rcnt == 4'h0)
                    next_state = fec_pkg::FEC_SQ_RECOV;
            fec_pkg::FEC_SQ_RECOV:
                if (rcnt == 4'h0)
                    next_state = fec_pkg::FEC_SQ_IDLE;
            default:
                next_state = fec_pkg::FEC_SQ_IDLE;
        endcase
    end

    // Sequencer state, step and reset pulse timing
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state         <= fec_pkg::FEC_SQ_IDLE;
            step          <= 3'd0;
            rcnt          <= 4'h0;
            flash_reset_n <= 1'b1;
        end
        else
        begin
            state         <= next_state;
            step          <= go_ok ? 3'd0 : ((state == fec_pkg::FEC_SQ_WAIT && eng_done) ?
                                             step + 3'd1 : step);
            rcnt          <= go_hwrst ? 4'(`FEC_RP_CYC - 1) :
                             (state == fec_pkg::FEC_SQ_HWRST && rcnt == 4'h0) ?
                             4'(`FEC_RH_CYC - 1) : ((rcnt != 4'h0) ? rcnt - 4'h1 : rcnt);
            flash_reset_n <= next_state != fec_pkg::FEC_SQ_HWRST;
        end
    end

    // Software registers
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            cur_op  <= fec_pkg::FEC_OP_READ;
            op_addr <= `FEC_ADDR_RST;
            op_data <= `FEC_DATA_RST;
        end
        else
        begin
            if (go_ok)
                cur_op <= fec_pkg::fec_op_t'(req_raw);
            if (apb_wr && paddr == `FEC_REG_ADDR)
                op_addr <= pwdata[17:0];
            if (apb_wr && paddr == `FEC_REG_WDATA)
                op_data <= pwdata[7:0];
        end
    end

    // Accumulation window tracking, opened at the final sector write
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            win_open <= 1'b0;
            win_cnt  <= 10'h000;
        end
        else if (sect_end)
        begin
            win_open <= 1'b1;
            win_cnt  <= 10'h000;
        end
        else if (seq_end || go_hwrst || (win_open && win_cnt == 10'(`FEC_WIN_CYC - 1)))
            win_open <= 1'b0;
        else if (win_open)
            win_cnt <= win_cnt + 10'h001;
    end

    // Sticky flags, set wins over write-one clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            refused    <= 1'b0;
            aborted    <= 1'b0;
            erase_live <= 1'b0;
            rb_q       <= 1'b1;
            rb_prev    <= 1'b1;
        end
        else
        begin
            rb_q       <= flash_ready_busy_n;
            rb_prev    <= rb_q;
            refused    <= (wr_ctrl && !go_ok) ||
                          (refused && !(wr_stat && pwdata[`FEC_ST_REFUSED]));
            aborted    <= (go_hwrst && erase_live) ||
                          (aborted && !(wr_stat && pwdata[`FEC_ST_ABORTED]));
            erase_live <= sect_end || chip_end ||
                          (erase_live && !rb_rise && !go_hwrst);
        end
    end

    fec_bus_cycle u_cycle
    (
        .clock      (clock),
        .rst        (rst),
        .start      (state == fec_pkg::FEC_SQ_ISSUE),
        .rd         (cyc.rd),
        .addr       (cyc.addr),
        .wdata      (cyc.data),
        .dq_in      (flash_dq_in),
        .done       (eng_done),
        .rdata      (eng_rdata),
        .flash_addr (flash_addr),
        .dq_out     (flash_dq_out),
        .dq_oe      (flash_dq_oe),
        .ce_n       (flash_ce_n),
        .we_n       (flash_we_n),
        .oe_n       (flash_oe_n)
    );

endmodule : fec_flash_ctrl

// >>> test/fec_flash_ctrl_sva.sv
// Port assertions for the flash erase controller
module fec_flash_ctrl_sva
(
    input wire logic        clock,
    input wire logic        rst,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [17:0] flash_addr,
    input wire logic        flash_dq_oe,
    input wire logic        flash_ce_n,
    input wire logic        flash_we_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_reset_n
);
    // All checks on the one clock, off during reset
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    a_write_gated: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
        else $error("write strobe without select or data");
    a_read_clean: assert property (!flash_oe_n |-> flash_we_n && !flash_dq_oe)
        else $error("read overlaps a write");
    a_write_pulse: assert property ($fell(flash_we_n) |=> flash_we_n && !flash_ce_n ##1 flash_ce_n)
        else $error("write pulse shape wrong");
    a_addr_held: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
        else $error("address moved within a cycle");
    a_reset_width: assert property ($fell(flash_reset_n) |-> !flash_reset_n [*5] ##1 flash_reset_n)
        else $error("reset pulse width wrong");
    a_reset_idle: assert property (!flash_reset_n |-> flash_ce_n && flash_we_n)
        else $error("strobes active during reset");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule : fec_flash_ctrl_sva

bind fec_flash_ctrl fec_flash_ctrl_sva i_fec_flash_ctrl_sva (.clock(clock), .rst(rst),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .flash_reset_n(flash_reset_n));

// >>> test/fec_flash_model.sv
// Behavioural flash device answering the controller
`include "fec_defs.svh"
module fec_flash_model
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic [17:0] addr,
    input  wire logic [7:0]  din,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    output logic [7:0]       dout,
    output logic             pull_low
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WIN = 500;
    localparam int ERASE = 300;
    logic [31:0] sel = '0;
    logic [9:0]  win = '0, run = '0;
    logic [2:0]  step = '0;
    logic [17:0] la = '0;
    logic [7:0]  last = '0;
    logic        susp = 0, chip = 0, pwe = 1, ids = 0, pgm = 0;
    logic [25:0] pv = '0;
    int          n_erase = 0;
    wire         wr = !pwe && we_n && !ce_n && oe_n;
    wire         two = step == 3'd1 || step == 3'd4;
    wire  [10:0] ea = two ? 11'h2AA : 11'h555;
    wire  [7:0]  ed = two ? 8'h55 : step == 3'd2 ? 8'h80 : 8'hAA;
    wire         busy = run != 0 || susp || win != 0;
    // Zero codes in identification mode, status in erase set, array elsewhere
    assign dout = (ce_n || oe_n) ? ~last : ids ? 8'h00 :
                  (sel[addr[17:13]] && busy) ? {susp, 7'h00} : addr[7:0];
    assign pull_low = run != 0 && !susp;
    // Command decoding and erase timing
    always @(posedge clock)
    begin
        pwe <= we_n;
        last <= dout;
        if (!we_n && !ce_n) la <= addr;
        if (!reset_n) {sel, win, run, step, susp, chip, ids, pgm} <= '0;
        else
        begin
            if (win == 10'd1) run <= 10'(ERASE);
            if (win != 0) win <= win - 1'b1;
            if (run == 10'd1 && !susp) {sel, n_erase} <= {32'h0, n_erase + 1};
            if (run != 0 && !susp) run <= run - 1'b1;
            if (wr && !(chip && run != 0))
            begin
                if (pgm) {pv, pgm} <= {la, din, 1'b0};
                else if (din == `FEC_CMD_SUSPEND && busy && !susp) {susp, win} <= {1'b1, 10'd0};
                else if (win != 0 && din == `FEC_CMD_SECTOR) {sel[la[17:13]], win} <= {1'b1, 10'(WIN)};
                else if (win != 0) {sel, win} <= '0;
                else if (susp && din == `FEC_CMD_RESUME) {susp, run} <= {1'b0, run != 0 ? run : 10'(ERASE)};
                else if ((run != 0 && !susp) || din == `FEC_CMD_RESET) {ids, step} <= '0;
                else if (step == 3'd5 && la[10:0] == 11'h555 && din == `FEC_CMD_CHIP) {sel, chip, run, step} <= {32'hFFFFFFFF, 1'b1, 10'(ERASE), 3'd0};
                else if (step == 3'd5 && din == `FEC_CMD_SECTOR) {sel[la[17:13]], chip, win, step} <= {1'b1, 1'b0, 10'(WIN), 3'd0};
                else if (step == 3'd2 && la[10:0] == ea && din == `FEC_CMD_AUTOSEL) {ids, step} <= {1'b1, 3'd0};
                else if (step == 3'd2 && la[10:0] == ea && din == `FEC_CMD_PROGRAM) {pgm, step} <= {1'b1, 3'd0};
                else step <= (la[10:0] == ea && din == ed) ? step + 1'b1 : 3'd0;
            end
        end
    end
endmodule : fec_flash_model

// >>> test/tb_fec_flash_ctrl.sv
// Self-checking bench for the flash erase controller
`include "fec_defs.svh"
module tb_fec_flash_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = '0, dq_out, dev_dq;
    logic [31:0] pwdata = '0, prdata, r, seed = 32'h0676;
    logic        pready, pslverr, dq_oe, ce_n, we_n, oe_n, reset_n, pull_low;
    logic [17:0] faddr, s1, s2;
    logic [65:0] exp_q[$], note;
    int          n_mismatch = 0, checked = 0, cyc = 0;
    wire  [7:0]  dq_in = dq_oe ? dq_out : dev_dq;
    wire         rb_n = !pull_low;

    // Clock
    always #50 clock = ~clock;

    fec_flash_ctrl i_fec_flash_ctrl (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flash_addr(faddr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
        .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
        .flash_reset_n(reset_n), .flash_ready_busy_n(rb_n));
    fec_flash_model i_fec_flash_model (.clock(clock), .reset_n(reset_n), .addr(faddr),
        .din(dq_out), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dout(dev_dq), .pull_low(pull_low));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic print_verdict;
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    // One transfer; a read notes its masked expectation first
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] m = '0, input logic [32:0] e = '0);
        @(posedge clock);
        if (!w) exp_q.push_back({m, e});
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        r = prdata;
        {psel, penable} <= 2'b00;
    endtask : apb

    // Launch an operation, then poll status until the chosen bits settle
    task automatic op(input logic [3:0] c, input logic [5:0] b = 6'h01, input logic [5:0] v = 6'h00);
        apb(1'b1, `FEC_REG_CTRL, {28'h0, c});
        do apb(1'b0, `FEC_REG_STATUS, 32'h0); while ((r[5:0] & b) !== v);
    endtask : op

    // Oldest note against each read answer
    always @(posedge clock)
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (note[65:33] != 0) cmp({pslverr, prdata} & note[65:33], note[32:0]);
        end

    // Cycle ceiling against hangs
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        apb(0, `FEC_REG_STATUS, 0, '1, 33'h2);
        apb(0, 8'h20, 0, '1, {1'b1, 32'h0});
        seed = lfsr(seed);
        s1 = seed[17:0];
        apb(1, `FEC_REG_ADDR, {14'h0, s1});
        op(6);
        apb(0, `FEC_REG_RDATA, 0, '1, {25'h0, s1[7:0]});
        apb(1, `FEC_REG_WDATA, seed);
        op(8);
        cmp({7'h0, i_fec_flash_model.pv}, {7'h0, s1, seed[7:0]});
        op(0);
        op(3, 6'h03, 6'h02);
        cmp(33'(i_fec_flash_model.n_erase), 33'd1);
        seed = lfsr(seed);
        s1 = seed[17:0];
        seed = lfsr(seed);
        s2 = seed[17:0];
        apb(1, `FEC_REG_ADDR, {14'h0, s1});
        op(1);
        apb(1, `FEC_REG_ADDR, {14'h0, s2});
        op(2);
        cmp({1'b0, i_fec_flash_model.sel}, {1'b0, (32'h1 << s1[17:13]) | (32'h1 << s2[17:13])});
        op(3);
        apb(0, `FEC_REG_STATUS, 0, 33'h4, 33'h0);
        op(7);
        apb(1, `FEC_REG_ADDR, {14'h0, s2[17:13], 13'h0002});
        op(6);
        apb(0, `FEC_REG_RDATA, 0, '1, 33'h0);
        op(5);
        apb(1, `FEC_REG_ADDR, {14'h0, s1});
        op(6);
        apb(0, `FEC_REG_RDATA, 0, 33'h80, 33'h80);
        op(4, 6'h03, 6'h02);
        cmp(33'(i_fec_flash_model.n_erase), 33'd2);
        apb(1, `FEC_REG_ADDR, {14'h0, s2});
        op(1);
        op(9);
        apb(0, `FEC_REG_STATUS, 0, 33'h14, 33'h10);
        cmp({1'b0, i_fec_flash_model.sel}, 33'h0);
        apb(1, `FEC_REG_STATUS, 32'h10);
        op(2);
        apb(0, `FEC_REG_STATUS, 0, 33'h18, 33'h08);
        apb(1, `FEC_REG_STATUS, 32'h08);
        apb(1, `FEC_REG_ADDR, {14'h0, s1});
        op(1);
        op(5);
        apb(0, `FEC_REG_STATUS, 0, 33'h0C, 33'h0);
        cmp({1'b0, i_fec_flash_model.sel}, 33'h0);
        print_verdict();
    end
endmodule : tb_fec_flash_ctrl
